// File: pars_top.sv
// Notes on behaviour
// [R1] Rolling mode while streaming steps rows, resetting each then reading it.
// [R2] Each row's reset-to-read interval is the same fixed exposure.
// [R3] Exposure changes take effect only at frame start; no mixed frames.
// [R4] Global mode captures one frame; shutter outputs end the exposure.
// [R5] Walk bounded by first/last settings; output size sets emitted dimensions.
// [R6] Default window gives 3264x2432; border reached only by reprogramming window.
// [R7] Mirror, default set, reads columns from last toward first.
// [R8] Flip reads rows from last toward first.
// [R9] Bayer order output tracks mirror and flip settings.
// [R10] Odd increments 1, 3, 7 accepted; other than 1 means subsampling.
// [R11] Both at 3 give 2x2 skipping, quarter size.
// [R12] Both at 7 give 4x4 skipping, one sixteenth size.
// [R13] Skip factor is (odd increment + 1) / 2.
// [R14] Software aligns start and span to four times the skip factor.
// [R15] Lines read equal (last - first + odd increment) / skip factor.
// [R16] Adjacent line pairs read; start alignment picks the phase.
// [R17] Software keeps line length constant across modes.
// [R18] Geometry settings take effect at next frame boundary.
module pars_top
   import pars_pkg::*;
#(
   parameter int LINE_CYC = 3300
) (
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              rst,
   // Mode control
   input  wire logic              stream_en,
   input  wire logic              rolling_shutter_mode,
   input  wire logic              global_release_capture_mode,
   input  wire logic              capture_start,
   // Window and output size
   input  wire logic [11:0]       x_first,
   input  wire logic [11:0]       y_first,
   input  wire logic [11:0]       x_last,
   input  wire logic [11:0]       y_last,
   input  wire logic [11:0]       x_out_size,
   input  wire logic [11:0]       y_out_size,
   // Orientation and subsampling
   input  wire logic              mirror,
   input  wire logic              flip,
   input  wire logic [3:0]        x_odd_inc,
   input  wire logic [3:0]        y_odd_inc,
   // Exposure in lines
   input  wire logic [15:0]       exposure_lines,
   // Array addressing
   output logic                   row_reset,
   output logic [11:0]            reset_row,
   output logic                   row_read,
   output logic [11:0]            read_row,
   // Pixel stream
   output logic                   pix_valid,
   output logic [11:0]            pix_col,
   output logic                   line_start,
   output logic                   frame_start,
   output logic                   frame_end,
   // Status
   output logic [1:0]             bayer_order,
   output logic [1:0]             x_skip,
   output logic [1:0]             y_skip,
   output logic                   cfg_error,
   // Mechanical shutter
   output logic                   shutter_open,
   output logic                   shutter_close
);
   initial begin
      if (LINE_CYC < 8 || LINE_CYC > 65535) begin
         $error("pars_top: LINE_CYC out of range");
      end
   end

   // ------------------------------------------------------------------
   // Frame-latched configuration
   // ------------------------------------------------------------------
   logic [11:0] f_xf, f_xl, f_yf, f_yl, f_xs, f_ys;
   logic [3:0]  f_xi, f_yi;
   logic [3:0]  x_inc_use, y_inc_use;
   logic        f_mir, f_flip;
   logic [15:0] f_exp;
   logic        frame_load;
   pars_state_t state;

   function automatic logic inc_ok(input logic [3:0] v);
      return (v == 4'h1) || (v == 4'h3) || (v == 4'h7);                  // [R10]
   endfunction

   // Illegal increments fall back to full resolution [R10]
   assign x_inc_use = inc_ok(x_odd_inc) ? x_odd_inc : ODD_INC_RST;
   assign y_inc_use = inc_ok(y_odd_inc) ? y_odd_inc : ODD_INC_RST;

   // Settings sampled only at frame start, so a frame never mixes geometry
   always_ff @(posedge clk) begin
      if (rst) begin
         f_xf  <= X_START_RST;
         f_xl  <= X_END_RST;
         f_yf  <= Y_START_RST;
         f_yl  <= Y_END_RST;
         f_xs  <= X_SIZE_RST;
         f_ys  <= Y_SIZE_RST;
         f_xi  <= ODD_INC_RST;
         f_yi  <= ODD_INC_RST;
         f_mir <= MIRROR_RST;
         f_flip<= FLIP_RST;
         f_exp <= EXP_RST;
      end else if (frame_load) begin                                    // [R18] [R6]
         f_xf  <= x_first;
         f_xl  <= x_last;
         f_yf  <= y_first;
         f_yl  <= y_last;
         f_xs  <= x_out_size;
         f_ys  <= y_out_size;
         f_xi  <= inc_ok(x_odd_inc) ? x_odd_inc : ODD_INC_RST;
         f_yi  <= inc_ok(y_odd_inc) ? y_odd_inc : ODD_INC_RST;
         f_mir <= mirror;
         f_flip<= flip;
         f_exp <= exposure_lines;                                      // [R3]
      end
   end

   // bayer_order and skips from the settings in use, cfg_error from the live increments
   always_ff @(posedge clk) begin
      if (rst) begin
         bayer_order <= BAYER_BASE ^ {FLIP_RST, MIRROR_RST};
         x_skip      <= 2'h1;
         y_skip      <= 2'h1;
         cfg_error   <= 1'b0;
      end else begin
         // Updated on the load edge, so status is valid with the frame marker
         if (frame_load) begin
            bayer_order <= BAYER_BASE ^ {flip, mirror};                // [R9]
            x_skip      <= 2'((x_inc_use + 4'h1) >> 1);                // [R13] [R11] [R12]
            y_skip      <= 2'((y_inc_use + 4'h1) >> 1);
         end
         cfg_error   <= !inc_ok(x_odd_inc) || !inc_ok(y_odd_inc);
      end
   end

   // ------------------------------------------------------------------
   // Line timer: one enable pulse per line time
   // ------------------------------------------------------------------
   logic [15:0] line_cnt;
   logic        line_tick;
   assign line_tick = (line_cnt == 16'(LINE_CYC - 1));
   always_ff @(posedge clk) begin
      if (rst || state == ST_IDLE) begin
         line_cnt <= '0;
      end else begin
         line_cnt <= line_tick ? 16'h0 : line_cnt + 16'h1;
      end
   end

   // ------------------------------------------------------------------
   // Row walkers: reset pointer leads read pointer by f_exp lines
   // ------------------------------------------------------------------
   logic [11:0] rd_row_a, rs_row_a, col_a;
   logic        rd_end, rs_end, col_end;
   logic        rd_step, rs_step, col_load;
   logic [15:0] line_idx;
   logic [11:0] rows_out, cols_out;
   logic        rs_done, rd_active, col_active;

   logic [11:0] y_lo, y_hi;
   logic [3:0]  y_step;
   logic        y_rev;
   // Live settings only on the load edge, then the frame's copy [R18]
   assign y_lo   = frame_load ? y_first : f_yf;
   assign y_hi   = frame_load ? y_last : f_yl;
   assign y_step = frame_load ? y_inc_use : f_yi;
   assign y_rev  = frame_load ? flip : f_flip;

   pars_axis #(.W(12)) u_rd (
      .clk(clk), .rst(rst), .load(frame_load), .step(rd_step),
      .first(y_lo), .last(y_hi), .odd_inc(y_step),
      .reverse(y_rev), .addr(rd_row_a), .at_end(rd_end));
   pars_axis #(.W(12)) u_rs (
      .clk(clk), .rst(rst), .load(frame_load), .step(rs_step),
      .first(y_lo), .last(y_hi), .odd_inc(y_step),
      .reverse(y_rev), .addr(rs_row_a), .at_end(rs_end));
   pars_axis #(.W(12)) u_col (
      .clk(clk), .rst(rst), .load(col_load), .step(col_active),
      .first(f_xf), .last(f_xl), .odd_inc(f_xi),
      .reverse(f_mir), .addr(col_a), .at_end(col_end));

   // Rolling: reset row k at line k, read it at line k+exp [R1] [R2]
   assign rs_step  = line_tick && state == ST_RUN && !rs_done;
   assign rd_step  = line_tick && rd_active && line_idx >= f_exp;
   assign col_load = line_tick && rd_active && (line_idx >= f_exp || state == ST_GREAD);
   assign frame_load = (state == ST_IDLE && stream_en && rolling_shutter_mode)
                     || (state == ST_IDLE && global_release_capture_mode && capture_start)
                     || (state == ST_RUN && frame_end && stream_en);

   // ------------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------------
   logic [15:0] shut_cnt;
   always_ff @(posedge clk) begin
      if (rst) begin
         state     <= ST_IDLE;
         line_idx  <= '0;
         rows_out  <= '0;
         rs_done   <= 1'b0;
         rd_active <= 1'b0;
         shut_cnt  <= '0;
      end else begin
         if (frame_load) begin
            line_idx  <= '0;
            rows_out  <= '0;
            rs_done   <= 1'b0;
            rd_active <= 1'b1;
         end else if (line_tick) begin
            line_idx <= line_idx + 16'h1;
            if (rs_end && state == ST_RUN) rs_done <= 1'b1;
            if (col_load) rows_out <= rows_out + 12'h1;
            if (col_load && (rd_end || rows_out + 12'h1 >= f_ys)) rd_active <= 1'b0; // [R5]
         end
         unique case (state)
            ST_IDLE: begin
               if (stream_en && rolling_shutter_mode) state <= ST_RUN;
               else if (global_release_capture_mode && capture_start) state <= ST_GRST; // [R4]
            end
            ST_RUN: begin
               if (frame_end && !stream_en) state <= ST_IDLE;
            end
            ST_GRST: begin
               shut_cnt <= 16'(SHUTTER_CYC);
               state    <= ST_GEXP;
            end
            ST_GEXP: begin
               if (line_tick && line_idx >= f_exp) begin
                  state    <= ST_GREAD;
               end
            end
            ST_GREAD: begin
               // Close command is a timed pulse, not a level held to the end
               if (shut_cnt != 16'h0) shut_cnt <= shut_cnt - 16'h1;
               if (frame_end) state <= ST_IDLE;
            end
         endcase
      end
   end

   logic        last_line;
   // Column walk counts pixels so emitted width follows output size [R5]
   always_ff @(posedge clk) begin
      if (rst) begin
         col_active <= 1'b0;
         cols_out   <= '0;
         last_line  <= 1'b0;
      end else if (col_load) begin
         col_active <= 1'b1;
         cols_out   <= '0;
         last_line  <= rd_end || rows_out + 12'h1 >= f_ys;
      end else if (col_active) begin
         cols_out <= cols_out + 12'h1;
         if (col_end || cols_out + 12'h1 >= f_xs) col_active <= 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // Registered outputs
   // ------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         row_reset     <= 1'b0;
         reset_row     <= '0;
         row_read      <= 1'b0;
         read_row      <= '0;
         pix_valid     <= 1'b0;
         pix_col       <= '0;
         line_start    <= 1'b0;
         frame_start   <= 1'b0;
         frame_end     <= 1'b0;
         shutter_open  <= 1'b0;
         shutter_close <= 1'b0;
      end else begin
         row_reset     <= rs_step || state == ST_GRST;                    // [R1]
         reset_row     <= rs_row_a;
         row_read      <= col_load;
         read_row      <= rd_row_a;
         pix_valid     <= col_active;
         pix_col       <= col_a;
         line_start    <= col_load;
         frame_start   <= frame_load;
         // Frame ends with the last pixel of its last line, so a reload never
         // lands while that line is still being walked [R18]
         frame_end     <= col_active && last_line && (col_end || cols_out + 12'h1 >= f_xs);
         // Shutter held open through exposure, closed when readout starts [R4]
         shutter_open  <= (state == ST_GRST) || (state == ST_GEXP);
         shutter_close <= (state == ST_GREAD) && shut_cnt != 16'h0;
      end
   end
endmodule : pars_top

// File: pars_pkg.sv
package pars_pkg;
   // ------------------------------------------------------------------
   // Array geometry and reset values
   // ------------------------------------------------------------------
   localparam int          ADDR_W         = 12;
   localparam int          EXP_W          = 16;
   localparam logic [11:0] X_START_RST    = 12'h008;
   localparam logic [11:0] Y_START_RST    = 12'h008;
   localparam logic [11:0] X_END_RST      = 12'h0cc7;   // 8 + 3264 - 1
   localparam logic [11:0] Y_END_RST      = 12'h0987;   // 8 + 2432 - 1
   localparam logic [11:0] X_SIZE_RST     = 12'hcc0;    // 3264
   localparam logic [11:0] Y_SIZE_RST     = 12'h990;    // 2448
   localparam logic [11:0] BORDER_MAX     = 12'h008;
   localparam logic [3:0]  ODD_INC_RST    = 4'h1;
   localparam logic        MIRROR_RST     = 1'b1;
   localparam logic        FLIP_RST       = 1'b0;
   localparam logic [EXP_W-1:0] EXP_RST   = 16'h0010;
   // Bayer phase codes: {row parity, column parity}
   localparam logic [1:0]  BAYER_BASE     = 2'h0;
   // ------------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------------
   localparam int          CLK_MHZ        = 125;
   localparam int          SHUTTER_NS     = 1000;
   localparam int          SHUTTER_CYC    = (SHUTTER_NS * CLK_MHZ + 999) / 1000;
   // Sequencer states
   typedef enum logic [4:0] {
      ST_IDLE  = 5'b00001,
      ST_RUN   = 5'b00010,
      ST_GRST  = 5'b00100,
      ST_GEXP  = 5'b01000,
      ST_GREAD = 5'b10000
   } pars_state_t;
endpackage : pars_pkg

// File: pars_axis.sv
// ----------------------------------------------------------------------
// One-axis address walker with mirror and odd-increment subsampling
// ----------------------------------------------------------------------
module pars_axis #(
   parameter int W = 12
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   // Control
   input  wire logic         load,
   input  wire logic         step,
   input  wire logic [W-1:0] first,
   input  wire logic [W-1:0] last,
   input  wire logic [3:0]   odd_inc,
   input  wire logic         reverse,
   // Status
   output logic [W-1:0]      addr,
   output logic              at_end
);
   import pars_pkg::*;

   logic [W-1:0] pair_gap;
   logic [W-1:0] next_addr;

   // Pairs of adjacent lines, then jump by odd_inc to the next pair [R16]
   assign pair_gap = {{(W-4){1'b0}}, odd_inc};                          // [R13]
   assign at_end   = reverse ? (addr <= first) : (addr >= last);
   always_comb begin
      if (!reverse) begin
         next_addr = addr[0] ? addr + pair_gap : addr + 1'b1;            // [R15]
      end else begin
         next_addr = addr[0] ? addr - 1'b1 : addr - pair_gap;           // [R7] [R8]
      end
   end

   // Reverse walk starts from the pair's upper line so pairs stay intact
   always_ff @(posedge clk) begin
      if (rst) begin
         addr <= '0;
      end else if (load) begin
         addr <= reverse ? last : first;
      end else if (step && !at_end) begin
         addr <= next_addr;
      end
   end
endmodule : pars_axis

// File: pars_top_assertions.sv
module pars_top_assertions #(
   parameter int LINE_CYC = 3300
) (
   // Clock and reset
   input wire logic       clk,
   input wire logic       rst,
   // Controls
   input wire logic       stream_en,
   input wire logic       rolling_shutter_mode,
   input wire logic       mirror,
   input wire logic       flip,
   input wire logic [3:0] x_odd_inc,
   input wire logic [3:0] y_odd_inc,
   // Observed outputs
   input wire logic       row_reset,
   input wire logic       row_read,
   input wire logic       pix_valid,
   input wire logic       line_start,
   input wire logic       frame_start,
   input wire logic [1:0] bayer_order,
   input wire logic [1:0] x_skip,
   input wire logic [1:0] y_skip,
   input wire logic       cfg_error,
   input wire logic       shutter_open,
   input wire logic       shutter_close
);
   import pars_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // Skip code as the port shows it; four wraps to zero in two bits
   function automatic logic [1:0] skf(input logic [3:0] v);
      return (v == 4'h3) ? 2'h2 : (v == 4'h7) ? 2'h0 : 2'h1;
   endfunction : skf
   // A line opens, then its pixel run follows shortly
   sequence s_line_open;
      row_read && line_start;
   endsequence
   sequence s_pix_run;
      ##[0:8] pix_valid;
   endsequence
   a_frame_pulse_single: assert property (frame_start |=> !frame_start)
      else $error("frame start longer than one cycle");
   a_bayer_phase: assert property (frame_start |-> bayer_order == ({flip, mirror} ^ BAYER_BASE))
      else $error("bayer order does not follow mirror and flip");
   a_skip_x_code: assert property (frame_start |-> x_skip == skf(x_odd_inc))
      else $error("x skip factor wrong");
   a_skip_y_code: assert property (frame_start |-> y_skip == skf(y_odd_inc))
      else $error("y skip factor wrong");
   a_odd_inc_legal: assert property (frame_start |->
         cfg_error == !(x_odd_inc inside {4'h1, 4'h3, 4'h7} && y_odd_inc inside {4'h1, 4'h3, 4'h7}))
      else $error("config error flag wrong");
   a_reset_state: assert property (disable iff (1'b0) $fell(rst) |->
         bayer_order == 2'h1 && x_skip == 2'h1 && y_skip == 2'h1)
      else $error("status wrong after reset");
   a_line_pixels: assert property (s_line_open |-> s_pix_run)
      else $error("line opened without pixels");
   a_read_marks_line: assert property (row_read |-> line_start)
      else $error("row read without line start");
   a_shutter_excl: assert property (!(shutter_open && shutter_close))
      else $error("shutter open and close together");
   a_shutter_order: assert property ($rose(shutter_close) |-> $past(shutter_open))
      else $error("shutter closed without exposure open");
   a_rows_spaced: assert property ((row_reset && stream_en && rolling_shutter_mode)
         |=> !row_reset [*8])
      else $error("row resets too close");
endmodule : pars_top_assertions

bind pars_top pars_top_assertions #(.LINE_CYC(LINE_CYC)) pars_top_assertions_inst (
   .clk, .rst, .stream_en, .rolling_shutter_mode, .mirror, .flip, .x_odd_inc, .y_odd_inc,
   .row_reset, .row_read, .pix_valid, .line_start, .frame_start, .bayer_order, .x_skip,
   .y_skip, .cfg_error, .shutter_open, .shutter_close);

// File: pars_host_sink.sv
module pars_host_sink (
   // Clock and reset
   input wire logic        clk,
   input wire logic        rst,
   // Array and stream side
   input wire logic        row_reset,
   input wire logic [11:0] reset_row,
   input wire logic        row_read,
   input wire logic [11:0] read_row,
   input wire logic        shutter_close,
   input wire logic        pix_valid,
   input wire logic [11:0] pix_col,
   input wire logic        frame_start,
   input wire logic        frame_end,
   // Frame summary
   output logic            done,
   output logic [11:0]     n_lines,
   output logic [15:0]     tot,
   output logic [11:0]     c0,
   output logic [11:0]     c1,
   output logic [11:0]     cl,
   output logic [11:0]     r0,
   output logic [11:0]     r1,
   output logic [31:0]     expo,
   output logic            uniform,
   output logic            shut
);
   int cyc;
   int rst_t [4096];
   // Host sink: totals per frame, pixels counted over the frame so no line edge is lost
   always @(posedge clk) begin
      cyc <= cyc + 1;
      done <= frame_end && !rst;
      if (rst) begin
         n_lines <= 12'h000;
         tot <= 16'h0000;
      end else begin
         if (frame_start) begin
            n_lines <= 12'h000;
            tot <= 16'h0000;
            uniform <= 1'b1;
            shut <= 1'b0;
         end
         if (shutter_close) shut <= 1'b1;
         if (row_reset) rst_t[reset_row] <= cyc;
         if (row_read) begin
            n_lines <= n_lines + 12'h001;
            if (n_lines == 12'h000) begin
               r0 <= read_row;
               expo <= cyc - rst_t[read_row];
            end else if (cyc - rst_t[read_row] != expo) uniform <= 1'b0;
            if (n_lines == 12'h001) r1 <= read_row;
         end
         if (pix_valid) begin
            tot <= tot + 16'h0001;
            if (tot == 16'h0000) c0 <= pix_col;
            if (tot == 16'h0001) c1 <= pix_col;
            cl <= pix_col;
         end
      end
   end
endmodule : pars_host_sink

// File: pars_top_test.sv
module pars_top_test;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int LINE = 32;   // Same line length in every mode
   typedef struct {
      logic [31:0] lines, tot, c0, c1, cl, r0, r1, e;
      logic        g;
   } pars_note_t;
   logic        clk, rst, stream_en, rolling_shutter_mode, global_release_capture_mode;
   logic        capture_start, mirror, flip, row_reset, row_read, pix_valid, line_start;
   logic        frame_start, frame_end, cfg_error, shutter_open, shutter_close;
   logic        done, uniform, shut;
   logic [11:0] x_first, y_first, x_last, y_last, x_out_size, y_out_size;
   logic [11:0] reset_row, read_row, pix_col, n_lines, c0, c1, cl, r0, r1;
   logic [3:0]  x_odd_inc, y_odd_inc;
   logic [15:0] exposure_lines, tot;
   logic [1:0]  bayer_order, x_skip, y_skip;
   logic [31:0] expo;
   logic [7:0]  lf;
   pars_note_t  q [$];
   pars_note_t  n;
   int          failures, checked, cyc, e1, e2;
   int          xi [5] = '{1, 3, 7, 3, 5};
   int          yi [5] = '{1, 3, 7, 1, 1};
   // --------
   // Design and host
   // --------
   pars_top #(.LINE_CYC(LINE)) pars_top_inst (.clk, .rst, .stream_en, .rolling_shutter_mode,
      .global_release_capture_mode, .capture_start, .x_first, .y_first, .x_last, .y_last,
      .x_out_size, .y_out_size, .mirror, .flip, .x_odd_inc, .y_odd_inc, .exposure_lines,
      .row_reset, .reset_row, .row_read, .read_row, .pix_valid, .pix_col, .line_start,
      .frame_start, .frame_end, .bayer_order, .x_skip, .y_skip, .cfg_error, .shutter_open,
      .shutter_close);
   pars_host_sink pars_host_sink_inst (.clk, .rst, .row_reset, .reset_row, .row_read,
      .read_row, .shutter_close, .pix_valid, .pix_col, .frame_start, .frame_end, .done,
      .n_lines, .tot, .c0, .c1, .cl, .r0, .r1, .expo, .uniform, .shut);
   // --------
   // Helpers
   // --------
   function automatic logic [7:0] lfsr(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction : lfsr
   // Lines read over a window starting at zero; illegal steps fall back to one
   function automatic int cnt(input int last, input int inc);
      int s;
      s = (inc == 3) ? 2 : (inc == 7) ? 4 : 1;
      return (last + ((s == 1) ? 1 : inc)) / s;
   endfunction : cnt
   // Window end kept aligned to four times the skip factor
   function automatic int lastv(input int inc, input int full);
      return (inc == 3) ? 13 : (inc == 7) ? 9 : full;
   endfunction : lastv
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (e !== g) begin
         failures++;
         $display("[FAIL] %s expected %0d seen %0d", nm, e, g);
      end
   endtask : chk
   task automatic push(input int e, input logic g);
      pars_note_t m;
      m.lines = y_out_size;
      m.tot = x_out_size * y_out_size;
      m.c0 = mirror ? x_last : 0;
      m.c1 = mirror ? x_last - 1 : 1;
      m.cl = mirror ? 0 : x_last;
      m.r0 = flip ? y_last : 0;
      m.r1 = flip ? y_last - 1 : 1;
      m.e = e * LINE;
      m.g = g;
      q.push_back(m);
   endtask : push
   task automatic wait_fs;
      do @(negedge clk); while (frame_start !== 1'b1);
   endtask : wait_fs
   task print_verdict;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : print_verdict
   // Clock, and a cycle ceiling well above four scenarios of two frames and one global capture
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         failures++;
         print_verdict;
      end
   end
   // Result watcher: oldest note against each finished frame
   always @(posedge clk) begin
      if (done === 1'b1) begin
         if (q.size() != 0) n = q.pop_front();
         else n = '{default: '1};
         chk("lines", n.lines, n_lines);
         chk("pixels", n.tot, tot);
         chk("first col", n.c0, c0);
         chk("second col", n.c1, c1);
         chk("last col", n.cl, cl);
         chk("first row", n.r0, r0);
         chk("second row", n.r1, r1);
         if (n.g === 1'b1) chk("shutter", 1, shut);
         else begin
            chk("exposure", n.e, expo);
            chk("uniform", 1, uniform);
         end
      end
   end
   // Stimulus at the falling edge, one scenario per table entry
   initial begin
      {rst, rolling_shutter_mode} = 2'h3;
      {stream_en, global_release_capture_mode, capture_start, mirror, flip} = 5'h00;
      {x_first, y_first, x_last, y_last} = 48'h0;
      {x_out_size, y_out_size, x_odd_inc, y_odd_inc} = 32'h0;
      exposure_lines = 16'h0001;
      lf = 8'h4a;
      repeat (3) @(negedge clk);
      rst = 1'b0;
      for (int i = 0; i < 5; i++) begin
         @(negedge clk);
         x_odd_inc = 4'(xi[i]);
         y_odd_inc = 4'(yi[i]);
         {flip, mirror} = 2'(i);
         x_last = 12'(lastv(xi[i], 15));
         y_last = 12'(lastv(yi[i], 7));
         x_out_size = 12'(cnt(x_last, xi[i]));
         y_out_size = 12'(cnt(y_last, yi[i]));
         lf = lfsr(lf);
         e1 = lf[1:0] + 1;
         lf = lfsr(lf);
         e2 = lf[1:0] + 1;
         exposure_lines = 16'(e1);
         if (i == 4) begin
            {rolling_shutter_mode, global_release_capture_mode, capture_start} = 3'h3;
            push(0, 1'b1);
            @(negedge clk);
            capture_start = 1'b0;
         end else begin
            stream_en = 1'b1;
            push(e1, 1'b0);
            push(e2, 1'b0);
            wait_fs;
            exposure_lines = 16'(e2);
            wait_fs;
            stream_en = 1'b0;
         end
         while (q.size() != 0) @(negedge clk);
         repeat (4) @(negedge clk);
         $display("test %0d done", i);
      end
      print_verdict;
   end
endmodule : pars_top_test
